// file: rtl/pdl_pkg.sv
// Functional notes
// - Self reset at power-up, finished once four clock cycles have occurred.
// - Sample the nine-bit data input each enabled edge, push to queue back.
// - Update the nine-bit data output each enabled edge from the queue front.
// - Active-low clock enable sampled on the edge; inactive stops the line, while the output buffer still drains.
// - Length is unsigned eleven-bit binary; latency equals length.
// - Sample length every enabled edge, compare with previous, restart delay on difference.
// - Word sampled at a length change emerges after exactly the new delay.
// - On length change zero all stored samples except the three at the front.
// - Length present after power-up counts as a new length, with zeroing.
// - Changing to the minimum length of five skips the zeroing; a length of five present at power-up is still zeroed.
// - Length below five or above 1317 takes no input; output is zero after the three old front words.
// - After change to x: three old words, x minus three zeros, then new data.
// - Active-low output enable acts asynchronously; inactive releases all data pins.
// - Fully static; a stopped clock in either phase keeps all data.
// - Cascaded stages give a total latency equal to the sum of stages.
package pdl_pkg;

   localparam int DATA_W     = 9;
   localparam int LEN_W      = 11;
   localparam int ADDR_W     = 11;
   localparam int LINE_DEPTH = 1317;
   localparam int FIFO_DEPTH = 16;

   localparam logic [LEN_W-1:0]  LEN_MIN     = 11'h005;
   localparam logic [LEN_W-1:0]  LEN_MAX     = 11'h525;
   localparam logic [LEN_W-1:0]  TEST_LO     = 11'h7c0;
   localparam logic [LEN_W-1:0]  TEST_HI     = 11'h7df;
   localparam logic [LEN_W-1:0]  FRONT_KEEP  = 11'h003;
   localparam logic [1:0]        FRONT_LAST  = 2'h2;
   localparam logic [2:0]        INIT_CYCLES = 3'h4;
   localparam logic [ADDR_W-1:0] WP_LAST     = 11'h524;
   localparam logic [ADDR_W:0]   DEPTH_WIDE  = 12'h525;

   typedef enum logic [1:0] {
      PDL_INIT  = 2'b00,
      PDL_FIRST = 2'b01,
      PDL_RUN   = 2'b10
   } pdl_state_e;

endpackage

// file: rtl/pdl_ram.sv
`timescale 1ns/10ps
module pdl_ram
   import pdl_pkg::*;
#(
   parameter int DW    = DATA_W,
   parameter int DEPTH = LINE_DEPTH,
   parameter int AW    = ADDR_W
)(
   input  wire logic          clk_in,
   input  wire logic          wr_en_in,
   input  wire logic [AW-1:0] wr_addr_in,
   input  wire logic [DW-1:0] wr_data_in,
   input  wire logic [AW-1:0] rd_addr_in,
   output logic      [DW-1:0] rd_data_out
);

   // Storage is plain flops with no refresh, so a stopped clock loses nothing
   logic [DW-1:0] mem_r [DEPTH];

   wire in_range = (32'(rd_addr_in) < DEPTH);

   assign rd_data_out = in_range ? mem_r[rd_addr_in] : '0;

   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem_r[wr_addr_in] <= wr_data_in;
      end
   end

endmodule

// file: rtl/pdl_fifo.sv
`timescale 1ns/10ps
module pdl_fifo
   import pdl_pkg::*;
#(
   parameter int W     = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
)(
   input  wire logic         clk_in,
   input  wire logic         sys_rst_in,
   input  wire logic         in_valid_in,
   output logic              in_ready_out,
   input  wire logic [W-1:0] in_data_in,
   output logic              out_valid_out,
   input  wire logic         out_ready_in,
   output logic      [W-1:0] out_data_out
);

   // Depth must be a power of two; pointers wrap by overflow
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0]   count_r;

   wire push = in_valid_in & in_ready_out;
   wire pop  = out_valid_out & out_ready_in;
   wire [AW:0] count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   assign in_ready_out  = (count_r != FULL_CNT);
   assign out_valid_out = (count_r != '0);
   assign out_data_out  = mem_r[rd_ptr_r];

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
      end else begin
         if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
            wr_ptr_r        <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         count_r <= count_nxt;
      end
   end

endmodule

// file: rtl/pdl_top.sv
`timescale 1ns/10ps
module pdl_top
   import pdl_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int FD = FIFO_DEPTH
)(
   input  wire logic             clk_in,
   input  wire logic             sys_rst_in,
   input  wire logic [DW-1:0]    din_in,
   input  wire logic [LEN_W-1:0] length_in,
   input  wire logic             clock_gate_n_in,
   input  wire logic             output_drive_n_in,
   input  wire logic             dout_ready_in,
   output logic                  data_taken_out,
   output logic      [DW-1:0]    dout_out,
   output logic                  dout_oe_out,
   output logic                  dout_valid_out
);

   ////////////////////////////////////////////////////////////////////////
   // State

   pdl_state_e        state_r;
   pdl_state_e        state_nxt;
   logic [2:0]        init_cnt_r;
   logic [LEN_W-1:0]  len_r;
   logic              ok_r;
   logic [LEN_W-1:0]  old_len_r;
   logic              old_ok_r;
   logic [1:0]        front_cnt_r;
   logic [LEN_W-1:0]  zero_cnt_r;
   logic [ADDR_W-1:0] wp_r;

   logic [2:0]        init_cnt_nxt;
   logic [LEN_W-1:0]  len_nxt;
   logic              ok_nxt;
   logic [LEN_W-1:0]  old_len_nxt;
   logic              old_ok_nxt;
   logic [1:0]        front_cnt_nxt;
   logic [LEN_W-1:0]  zero_cnt_nxt;
   logic [ADDR_W-1:0] wp_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Decode

   logic              fifo_ready;
   logic              running;
   logic              adv;
   logic              len_diff;
   logic              chg;
   logic              new_ok;
   logic              front_on;
   logic [LEN_W-1:0]  rd_len;
   logic              rd_ok;
   logic              zeroing;
   logic              wr_ok;
   logic [DW-1:0]     wr_data;
   logic [ADDR_W:0]   rd_wrap;
   logic [ADDR_W-1:0] rd_addr;
   logic [DW-1:0]     rd_data;
   logic [DW-1:0]     line_word;
   logic              min_skip;
   logic [LEN_W-1:0]  zero_load;

   assign running = (state_r != PDL_INIT);

   // Full output buffer stalls the line like an inactive enable
   assign adv = running & ~clock_gate_n_in & fifo_ready;

   assign len_diff = (length_in != len_r);

   // Detection only on enabled edges; first enabled edge always counts
   assign chg = adv & ((state_r == PDL_FIRST) | len_diff);

   // Reserved test codes fall above the legal maximum
   assign new_ok = (length_in >= LEN_MIN) & (length_in <= LEN_MAX);

   assign front_on = (front_cnt_r != 2'h0);

   // Front words are read with the length that was in force before
   assign rd_len = (front_on & ~chg) ? old_len_r : len_r;
   assign rd_ok  = (front_on & ~chg) ? old_ok_r : ok_r;

   assign zeroing = (zero_cnt_r != '0) & ~front_on & ~chg;

   assign wr_ok   = chg ? new_ok : ok_r;
   assign wr_data = wr_ok ? din_in : '0;

   // Read address trails the write pointer by the length
   assign rd_wrap = {1'b0, wp_r} + DEPTH_WIDE - {1'b0, rd_len};
   assign rd_addr = (wp_r >= rd_len) ? (wp_r - rd_len) : rd_wrap[ADDR_W-1:0];

   assign line_word = (rd_ok & ~zeroing) ? rd_data : '0;

   assign wp_nxt = adv ? ((wp_r == WP_LAST) ? '0 : wp_r + 1'b1) : wp_r;

   ////////////////////////////////////////////////////////////////////////
   // Length change bookkeeping

   // Power-up change always zeroes, even to the minimum length
   assign min_skip  = (state_r == PDL_RUN) & (length_in == LEN_MIN);
   assign zero_load = (new_ok & ~min_skip) ? (length_in - FRONT_KEEP) : '0;

   assign len_nxt     = chg ? length_in : len_r;
   assign ok_nxt      = chg ? new_ok : ok_r;
   assign old_len_nxt = chg ? len_r : old_len_r;
   assign old_ok_nxt  = chg ? ok_r : old_ok_r;

   assign front_cnt_nxt = chg ? FRONT_LAST :
                          (adv & front_on) ? (front_cnt_r - 2'h1) : front_cnt_r;

   assign zero_cnt_nxt = chg ? zero_load :
                         (adv & zeroing) ? (zero_cnt_r - 1'b1) : zero_cnt_r;

   assign init_cnt_nxt = (state_r == PDL_INIT) ? (init_cnt_r + 3'h1) : init_cnt_r;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         PDL_INIT: begin
            if (init_cnt_r == (INIT_CYCLES - 3'h1)) begin
               state_nxt = PDL_FIRST;
            end
         end
         PDL_FIRST: begin
            if (chg) begin
               state_nxt = PDL_RUN;
            end
         end
         PDL_RUN: begin
            state_nxt = PDL_RUN;
         end
         default: begin
            state_nxt = PDL_INIT;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers; all state is static flops

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_r     <= PDL_INIT;
         init_cnt_r  <= '0;
         len_r       <= '0;
         ok_r        <= 1'b0;
         old_len_r   <= '0;
         old_ok_r    <= 1'b0;
         front_cnt_r <= '0;
         zero_cnt_r  <= '0;
         wp_r        <= '0;
      end else begin
         state_r     <= state_nxt;
         init_cnt_r  <= init_cnt_nxt;
         len_r       <= len_nxt;
         ok_r        <= ok_nxt;
         old_len_r   <= old_len_nxt;
         old_ok_r    <= old_ok_nxt;
         front_cnt_r <= front_cnt_nxt;
         zero_cnt_r  <= zero_cnt_nxt;
         wp_r        <= wp_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Delay store and output buffer

   pdl_ram #(
      .DW    (DW),
      .DEPTH (LINE_DEPTH),
      .AW    (ADDR_W)
   ) u_ram (
      .clk_in      (clk_in),
      .wr_en_in    (adv),
      .wr_addr_in  (wp_r),
      .wr_data_in  (wr_data),
      .rd_addr_in  (rd_addr),
      .rd_data_out (rd_data)
   );

   // Line output lands in the buffer on the same edge it would hit the pins
   pdl_fifo #(
      .W     (DW),
      .DEPTH (FD)
   ) u_fifo (
      .clk_in        (clk_in),
      .sys_rst_in    (sys_rst_in),
      .in_valid_in   (adv),
      .in_ready_out  (fifo_ready),
      .in_data_in    (line_word),
      .out_valid_out (dout_valid_out),
      .out_ready_in  (dout_ready_in),
      .out_data_out  (dout_out)
   );

   assign data_taken_out = adv;

   // Release is combinational, independent of the clock
   assign dout_oe_out = ~output_drive_n_in;

   ////////////////////////////////////////////////////////////////////////
   // Checking helpers

   logic              cap_armed_r;
   logic [LEN_W-1:0]  cap_cnt_r;
   logic [LEN_W-1:0]  cap_len_r;
   logic              cap_ok_r;
   logic [DW-1:0]     cap_data_r;
   logic              cap_hit;

   assign cap_hit = cap_armed_r & adv & ~chg & (cap_cnt_r == (cap_len_r - 1'b1));

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cap_armed_r <= 1'b0;
         cap_cnt_r   <= '0;
         cap_len_r   <= '0;
         cap_ok_r    <= 1'b0;
         cap_data_r  <= '0;
      end else if (chg) begin
         cap_armed_r <= 1'b1;
         cap_cnt_r   <= '0;
         cap_len_r   <= length_in;
         cap_ok_r    <= new_ok;
         cap_data_r  <= din_in;
      end else if (adv & cap_armed_r) begin
         cap_cnt_r <= cap_cnt_r + 1'b1;
         if (cap_hit) begin
            cap_armed_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   init_wait_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == PDL_INIT) && (init_cnt_r != (INIT_CYCLES - 3'h1))
      |=> (state_r == PDL_INIT) && !data_taken_out
   ) else $error("line left init too early");

   init_done_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == PDL_INIT) && (init_cnt_r == (INIT_CYCLES - 3'h1))
      |=> (state_r == PDL_FIRST)
   ) else $error("line did not leave init");

   write_step_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      adv && (wp_r != WP_LAST) |=> (wp_r == $past(wp_r) + 1'b1)
   ) else $error("write pointer did not advance");

   out_push_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      adv |=> dout_valid_out
   ) else $error("line word not presented");

   gate_stop_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      clock_gate_n_in |=> $stable(wp_r) && $stable(zero_cnt_r)
   ) else $error("line moved while disabled");

   delay_exact_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      cap_hit && cap_ok_r |-> (line_word == cap_data_r)
   ) else $error("word at change not out after new delay");

   detect_len_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      adv && len_diff |=> (len_r == $past(length_in)) && (front_cnt_r == FRONT_LAST)
   ) else $error("length change not taken");

   zero_fill_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      adv && zeroing |-> (line_word == '0)
   ) else $error("stale word escaped zeroing");

   zero_load_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      chg && new_ok && (state_r == PDL_FIRST)
      |=> (zero_cnt_r == $past(length_in) - FRONT_KEEP)
   ) else $error("zero run length wrong");

   first_chg_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      (state_r == PDL_FIRST) && adv |-> chg
   ) else $error("power-up length not treated as new");

   min_skip_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      chg && (state_r == PDL_RUN) && (length_in == LEN_MIN) |=> (zero_cnt_r == '0)
   ) else $error("zeroing not skipped for minimum");

   bad_len_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      adv && !ok_r && !front_on && !chg |-> (line_word == '0) && (wr_data == '0)
   ) else $error("illegal length passed data");

   drive_off_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      output_drive_n_in |-> !dout_oe_out
   ) else $error("pins driven while released");

   hold_idle_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      !adv |=> $stable(len_r) && $stable(front_cnt_r)
   ) else $error("state moved while held");

   // Unpopped head word must not slip while downstream holds off
   out_hold_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      dout_valid_out && !dout_ready_in
      |=> dout_valid_out && $stable(dout_out)
   ) else $error("head word changed before it was taken");

   read_gap_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      adv && ok_r && !front_on && !chg
      |-> ((int'(wp_r) - int'(rd_addr) + LINE_DEPTH) % LINE_DEPTH) == (int'(len_r) % LINE_DEPTH)
   ) else $error("read point not one length behind write");

   zero_run_a: assert property (
      @(posedge clk_in) disable iff (sys_rst_in)
      chg && new_ok && (state_r == PDL_RUN) && (length_in != LEN_MIN)
      |=> (zero_cnt_r == $past(length_in) - FRONT_KEEP) && (front_cnt_r == FRONT_LAST)
   ) else $error("zero run after change wrong");

endmodule

// file: testbench/pdl_sink.sv
`timescale 1ns/10ps
module pdl_sink (
   input  wire logic clk_in,
   input  wire logic stall_in,
   input  wire logic slow_in,
   output logic      ready_out
);
   logic [1:0] phase_r = 2'h0;

   // Downstream takes a word every cycle, every third cycle, or none at all
   always @(negedge clk_in) begin
      phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
      ready_out <= !stall_in && (!slow_in || phase_r == 2'h0);
   end
endmodule

// file: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
   import pdl_pkg::*;
   logic             clk_in;
   logic             sys_rst_in;
   logic [8:0]       din_in;
   logic [LEN_W-1:0] length_in;
   logic             clock_gate_n_in;
   logic             output_drive_n_in;
   logic             dout_ready_in;
   logic             data_taken_out;
   logic [8:0]       dout_out;
   logic             dout_oe_out;
   logic             dout_valid_out;
   logic             stall;
   logic             slow;
   int               fails;
   int               samples_checked;
   int               cycles;
   logic [9:0]       line_q[$];
   logic [9:0]       exp_q[$];
   logic [LEN_W-1:0] held_len;
   logic             held_ok;

   pdl_top dut (
      .clk_in            (clk_in),
      .sys_rst_in        (sys_rst_in),
      .din_in            (din_in),
      .length_in         (length_in),
      .clock_gate_n_in   (clock_gate_n_in),
      .output_drive_n_in (output_drive_n_in),
      .dout_ready_in     (dout_ready_in),
      .data_taken_out    (data_taken_out),
      .dout_out          (dout_out),
      .dout_oe_out       (dout_oe_out),
      .dout_valid_out    (dout_valid_out)
   );

   pdl_sink sink (
      .clk_in    (clk_in),
      .stall_in  (stall),
      .slow_in   (slow),
      .ready_out (dout_ready_in)
   );

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   always @(negedge clk_in) begin
      din_in <= din_in + 9'h001;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      if (fails == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic legal(input logic [LEN_W-1:0] l);
      return l >= LEN_MIN && l <= LEN_MAX;
   endfunction

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 6000) begin
         $display("[FAIL] t=%0t cycles=%h limit=%h", $time, cycles, 6000);
         fails++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference line: one word out per taken edge, one in while the length is legal; bit 9 marks
   // a word whose value is left open
   always @(posedge clk_in) begin
      logic [9:0] w;
      if (sys_rst_in) begin
         line_q.delete();
         exp_q.delete();
         held_ok = 1'b0;
      end else begin
         if (dout_valid_out && dout_ready_in) begin
            w = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h1ff;
            if (!w[9]) chk({1'b0, dout_out}, w);
         end
         if (data_taken_out) begin
            if (!held_ok) begin
               line_q.delete();
               repeat (legal(length_in) ? length_in : 0) line_q.push_back(10'h000);
            end else if (length_in != held_len) begin
               while (line_q.size() > 3) void'(line_q.pop_back());
               while (line_q.size() < 3) line_q.push_back(10'h200);
               while (legal(length_in) && line_q.size() < length_in) begin
                  line_q.push_back(length_in == LEN_MIN ? 10'h200 : 10'h000);
               end
            end
            held_ok = 1'b1;
            held_len = length_in;
            w = (line_q.size() > 0) ? line_q.pop_front() : 10'h000;
            if (legal(held_len)) line_q.push_back({1'b0, din_in});
            exp_q.push_back(w);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic run(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   task automatic sc_powerup(input logic [LEN_W-1:0] len);
      int n;
      n = 0;
      sys_rst_in = 1'b1;
      length_in = len;
      run(10);
      chk({1'b0, dout_valid_out, 7'h00, data_taken_out}, 10'h000);
      sys_rst_in = 1'b0;
      while (data_taken_out !== 1'b1 && n < 10) begin
         run(1);
         n++;
      end
      chk(10'(n), 10'h004);
      run(40);
   endtask

   task automatic sc_change();
      length_in = 11'h007;
      run(20);
      length_in = LEN_MIN;
      run(20);
      length_in = 11'h006;
      run(20);
   endtask

   task automatic sc_gate();
      clock_gate_n_in = 1'b1;
      run(2);
      length_in = 11'h008;
      run(3);
      chk({9'h000, data_taken_out}, 10'h000);
      length_in = 11'h006;
      run(3);
      clock_gate_n_in = 1'b0;
      run(20);
   endtask

   task automatic sc_full();
      stall = 1'b1;
      run(30);
      chk({dout_valid_out, data_taken_out, 8'h00}, 10'h200);
      stall = 1'b0;
      slow = 1'b1;
      run(60);
      slow = 1'b0;
      run(30);
   endtask

   task automatic sc_oe();
      output_drive_n_in = 1'b1;
      #1;
      chk({9'h000, dout_oe_out}, 10'h000);
      output_drive_n_in = 1'b0;
      #1;
      chk({9'h000, dout_oe_out}, 10'h001);
   endtask

   // Reserved test lengths are never programmed
   task automatic sc_illegal();
      length_in = 11'h004;
      run(15);
      length_in = 11'h526;
      run(10);
      length_in = LEN_MAX;
      run(1340);
      length_in = 11'h006;
      run(20);
   endtask

   task automatic sc_drain();
      int n;
      n = 0;
      clock_gate_n_in = 1'b1;
      while (dout_valid_out === 1'b1 && n < 40) begin
         run(1);
         n++;
      end
      chk(10'(exp_q.size()), 10'h000);
      clock_gate_n_in = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst_in = 1'b1;
      din_in = 9'h000;
      length_in = 11'h006;
      clock_gate_n_in = 1'b0;
      output_drive_n_in = 1'b0;
      stall = 1'b0;
      slow = 1'b0;
      fails = 0;
      samples_checked = 0;
      cycles = 0;
      sc_powerup(11'h006);
      sc_change();
      sc_gate();
      sc_full();
      sc_oe();
      sc_illegal();
      sc_powerup(LEN_MIN);
      sc_change();
      sc_drain();
      wrap_up();
   end
endmodule
